// ---- core/pal_ch_if.sv ----
`timescale 1ns/1ps
interface pal_ch_if;
  logic [pal_pkg::NCH-1:0] active;
  logic [pal_pkg::NCH-1:0] acked;
  logic [pal_pkg::NCH-1:0] safe_unack;
  logic [pal_pkg::NCH-1:0] relay_drive;
  modport chan (output active, output acked, output safe_unack,
                output relay_drive);
  modport top (input active, input acked, input safe_unack,
               input relay_drive);
endinterface : pal_ch_if

// ---- core/pal_channel.sv ----
`timescale 1ns/1ps
module pal_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restore,
  input wire logic [2:0] nv_in,
  input wire logic cond,
  input wire logic safe_now,
  input wire logic ack,
  input wire pal_pkg::pal_latch_t latch,
  input wire logic block_en,
  output logic active,
  output logic acked,
  output logic safe_unack,
  output logic relay_drive
);
  typedef struct packed {
    logic active;
    logic acked;
    logic safe_unack;
    logic blocked;
  } pal_chs_t;
  pal_chs_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (restore) begin
      st_next.active = nv_in[0];
      st_next.acked = nv_in[1];
      st_next.safe_unack = nv_in[2];
      st_next.blocked = 1'b0;
      unique case (latch)
        pal_pkg::LATCH_NONE, pal_pkg::LATCH_EVENT_ONLY: begin
          st_next.safe_unack = 1'b0;
          st_next.blocked = block_en && nv_in[0];
          if (safe_now || block_en) begin
            st_next.active = 1'b0;
            st_next.acked = 1'b0;
          end
        end
        pal_pkg::LATCH_AUTO: begin
          if (block_en && nv_in[0] && nv_in[1]) begin
            st_next.blocked = 1'b1;
            st_next.active = 1'b0;
            st_next.acked = 1'b0;
          end else if (nv_in[0] && safe_now) begin
            st_next.active = 1'b0;
            st_next.safe_unack = !nv_in[1];
            st_next.acked = 1'b0;
          end
        end
        pal_pkg::LATCH_MANUAL: begin
          if (nv_in[0] && safe_now) begin
            st_next.active = 1'b0;
            st_next.safe_unack = 1'b1;
            st_next.acked = 1'b0;
          end
        end
      endcase
    end else begin
      // start-up mask lifts only once the process is seen safe
      if (st_reg.blocked && safe_now)
        st_next.blocked = 1'b0;
      if (cond && !st_reg.blocked && !st_reg.active) begin
        st_next.active = 1'b1;
        st_next.acked = 1'b0;
        st_next.safe_unack = 1'b0;
      end
      if (st_reg.active || st_reg.safe_unack) begin
        unique case (latch)
          pal_pkg::LATCH_NONE, pal_pkg::LATCH_EVENT_ONLY: begin
            if (!cond) begin
              st_next.active = 1'b0;
              st_next.acked = 1'b0;
            end else if (ack)
              st_next.acked = 1'b1;
          end
          pal_pkg::LATCH_AUTO: begin
            if (ack && !cond) begin
              st_next.active = 1'b0;
              st_next.safe_unack = 1'b0;
              st_next.acked = 1'b0;
            end else if (ack)
              st_next.acked = 1'b1;
            else if (!cond && st_reg.acked) begin
              st_next.active = 1'b0;
              st_next.acked = 1'b0;
            end else if (!cond) begin
              st_next.active = 1'b0;
              st_next.safe_unack = 1'b1;
            end
          end
          pal_pkg::LATCH_MANUAL: begin
            if (!cond && ack) begin
              st_next.active = 1'b0;
              st_next.safe_unack = 1'b0;
            end else if (!cond) begin
              st_next.active = 1'b0;
              st_next.safe_unack = 1'b1;
            end
          end
        endcase
      end
    end
    if (!aresetn)
      st_next = '0;
  end

  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  assign active = st_reg.active;
  assign acked = st_reg.acked;
  assign safe_unack = st_reg.safe_unack;
  // latch none: relay driven while alarm active and unacknowledged; other modes: while active or safe_unack
  assign relay_drive = (latch == pal_pkg::LATCH_NONE) ?
    (st_reg.active && !st_reg.acked) :
    (st_reg.active || st_reg.safe_unack);
endmodule : pal_channel

// ---- core/pal_pkg.sv ----
package pal_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam int NOUT = 4;
  localparam int VW = 16;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CH_BASE = 8'h00;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_TRIP = 8'h04;
  localparam logic [7:0] OFS_HYST = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_PV = 8'h40;
  localparam logic [7:0] OFS_MAP = 8'h44;
  localparam logic [7:0] OFS_ACK = 8'h48;
  localparam logic [7:0] OFS_IND = 8'h4C;
  localparam logic [7:0] OFS_NV = 8'h50;

  // cfg word fields
  localparam int CFG_KIND_LSB = 0;
  localparam int CFG_LATCH_LSB = 4;
  localparam int CFG_BLOCK_BIT = 8;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_FULL_HIGH = 3'h1,
    KIND_FULL_LOW = 3'h2,
    KIND_DEVIATION_HIGH = 3'h3,
    KIND_DEVIATION_LOW = 3'h4,
    KIND_DEVIATION_BAND = 3'h5,
    KIND_RISING_RATE = 3'h6,
    KIND_FALLING_RATE = 3'h7
  } pal_kind_t;

  typedef enum logic [1:0] {
    LATCH_MANUAL = 2'h0,
    LATCH_EVENT_ONLY = 2'h1,
    LATCH_NONE = 2'h2,
    LATCH_AUTO = 2'h3
  } pal_latch_t;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam pal_kind_t KIND_RST = KIND_NONE;
  localparam pal_latch_t LATCH_RST = LATCH_MANUAL;
  localparam logic BLOCK_RST = 1'b0;
  localparam logic [VW-1:0] TRIP_RST = 16'h0000;
  localparam logic [VW-1:0] HYST_RST = 16'h0000;
  localparam logic [15:0] MAP_RST = 16'h0000;
  localparam int CLK_HZ = 50_000_000;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  localparam int ROT_MS = 2000;
  localparam int ROT_CYC = CLK_HZ / 1000 * ROT_MS;
  localparam int RATE_S = 60;
endpackage : pal_pkg

// ---- core/pal_top.sv ----
`timescale 1ns/1ps
module pal_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] process_value,
  input wire logic [15:0] setpoint,
  input wire logic operator_ack,
  input wire logic nv_restore,
  input wire logic [11:0] nv_state_in,
  output logic [11:0] nv_state_out,
  output logic alarm_beacon,
  output logic [3:0] message_channel,
  output logic [2:0] message_kind,
  output logic message_valid,
  output logic [3:0] relay_out
);
  localparam int NCH = pal_pkg::NCH;

  typedef struct packed {
    logic [NCH-1:0][2:0] kind;
    logic [NCH-1:0][1:0] latch;
    logic [NCH-1:0] block_en;
    logic [NCH-1:0][15:0] trip;
    logic [NCH-1:0][15:0] hyst;
    logic [15:0] relay_map;
    logic [NCH-1:0] cond;
    logic [15:0] pv_last;
    logic [31:0] rate_cnt;
    logic [31:0] flash_cnt;
    logic flash;
    logic [31:0] rot_cnt;
    logic [1:0] rot_idx;
    logic [3:0] msg_ch;
    logic [2:0] msg_kind;
    logic msg_valid;
    logic ack;
    logic [7:0] waddr;
    logic aw_have;
    logic [31:0] wdata;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [11:0] nv;
  } pal_st_t;
  pal_st_t st_reg, st_next;

  pal_ch_if chb ();

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  function automatic logic [2:0] pal_chan_of(input logic [7:0] a);
    pal_chan_of = {a[6], a[5:4]};
  endfunction : pal_chan_of

  function automatic logic [7:0] pal_off_of(input logic [7:0] a);
    pal_off_of = {4'h0, a[3:0]};
  endfunction : pal_off_of

  // ------------------------------------------------------------------
  // channels
  // ------------------------------------------------------------------
  logic [NCH-1:0] safe_now;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      pal_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .restore(nv_restore),
        .nv_in(nv_state_in[3*g +: 3]),
        .cond(st_reg.cond[g]),
        .safe_now(safe_now[g]),
        .ack(st_reg.ack),
        .latch(pal_pkg::pal_latch_t'(st_reg.latch[g])),
        .block_en(st_reg.block_en[g]),
        .active(chb.active[g]),
        .acked(chb.acked[g]),
        .safe_unack(chb.safe_unack[g]),
        .relay_drive(chb.relay_drive[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [16:0] lo;
    logic [16:0] hi;
    logic [16:0] dv;
    logic [16:0] rate;
    logic [16:0] band;
    logic trip_hit;
    logic clear_hit;
    logic rate_tick;
    logic [2:0] c;
    logic [7:0] o;
    logic any_unack;
    logic any_acked;
    lo = '0;
    hi = '0;
    dv = '0;
    rate = '0;
    band = '0;
    trip_hit = 1'b0;
    clear_hit = 1'b0;
    rate_tick = 1'b0;
    c = '0;
    o = '0;
    any_unack = 1'b0;
    any_acked = 1'b0;
    st_next = st_reg;
    st_next.ack = operator_ack;
    rate_tick = (st_reg.rate_cnt == 32'(pal_pkg::CLK_HZ * 1) - 32'd1);
    st_next.rate_cnt = rate_tick ? '0 : st_reg.rate_cnt + 32'd1;
    if (rate_tick)
      st_next.pv_last = process_value;
    // per-unit-minute threshold taken as per-second delta times 60
    for (int i = 0; i < NCH; i++) begin
      dv = {1'b0, process_value} - {1'b0, setpoint};
      rate = ({1'b0, process_value} - {1'b0, st_reg.pv_last});
      unique case (pal_pkg::pal_kind_t'(st_reg.kind[i]))
        pal_pkg::KIND_NONE: begin
          trip_hit = 1'b0;
          clear_hit = 1'b1;
        end
        pal_pkg::KIND_FULL_HIGH: begin
          trip_hit = process_value > st_reg.trip[i];
          lo = {1'b0, st_reg.trip[i]} - {1'b0, st_reg.hyst[i]};
          clear_hit = {1'b0, process_value} < lo;
        end
        pal_pkg::KIND_FULL_LOW: begin
          trip_hit = process_value < st_reg.trip[i];
          hi = {1'b0, st_reg.trip[i]} + {1'b0, st_reg.hyst[i]};
          clear_hit = {1'b0, process_value} > hi;
        end
        pal_pkg::KIND_DEVIATION_HIGH: begin
          hi = {1'b0, setpoint} + {1'b0, st_reg.trip[i]};
          lo = hi - {1'b0, st_reg.hyst[i]};
          trip_hit = {1'b0, process_value} > hi;
          clear_hit = {1'b0, process_value} < lo;
        end
        pal_pkg::KIND_DEVIATION_LOW: begin
          lo = {1'b0, setpoint} - {1'b0, st_reg.trip[i]};
          hi = lo + {1'b0, st_reg.hyst[i]};
          trip_hit = {1'b0, process_value} < lo;
          clear_hit = {1'b0, process_value} > hi;
        end
        pal_pkg::KIND_DEVIATION_BAND: begin
          band = dv[16] ? (17'd0 - dv) : dv;
          trip_hit = band > {1'b0, st_reg.trip[i]};
          clear_hit = band + {1'b0, st_reg.hyst[i]} <
                      {1'b0, st_reg.trip[i]};
        end
        pal_pkg::KIND_RISING_RATE: begin
          // widened so that a fast ramp cannot wrap below the threshold
          trip_hit = !rate[16] &&
            (32'(rate[15:0]) * 32'(pal_pkg::RATE_S)) > 32'(st_reg.trip[i]);
          clear_hit = !trip_hit;
        end
        pal_pkg::KIND_FALLING_RATE: begin
          band = 17'd0 - rate;
          trip_hit = rate[16] &&
            (32'(band[15:0]) * 32'(pal_pkg::RATE_S)) > 32'(st_reg.trip[i]);
          clear_hit = !trip_hit;
        end
      endcase
      if (trip_hit)
        st_next.cond[i] = 1'b1;
      else if (clear_hit)
        st_next.cond[i] = 1'b0;
    end

    // beacon flash and message rotation dividers
    if (st_reg.flash_cnt == 32'(pal_pkg::FLASH_CYC) - 32'd1) begin
      st_next.flash_cnt = '0;
      st_next.flash = !st_reg.flash;
    end else
      st_next.flash_cnt = st_reg.flash_cnt + 32'd1;
    st_next.msg_valid = 1'b0;
    if (st_reg.rot_cnt == 32'(pal_pkg::ROT_CYC) - 32'd1) begin
      st_next.rot_cnt = '0;
      st_next.rot_idx = st_reg.rot_idx + 2'd1;
    end else
      st_next.rot_cnt = st_reg.rot_cnt + 32'd1;
    for (int i = 0; i < NCH; i++) begin
      if ((chb.active[i] || chb.safe_unack[i]) &&
          !st_next.msg_valid &&
          2'(i) >= st_reg.rot_idx) begin
        st_next.msg_valid = 1'b1;
        st_next.msg_ch = 4'(i + 1);
        st_next.msg_kind = st_reg.kind[i];
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if ((chb.active[i] || chb.safe_unack[i]) && !st_next.msg_valid) begin
        st_next.msg_valid = 1'b1;
        st_next.msg_ch = 4'(i + 1);
        st_next.msg_kind = st_reg.kind[i];
      end
    end

    st_next.nv = {chb.safe_unack[3], chb.acked[3], chb.active[3],
                  chb.safe_unack[2], chb.acked[2], chb.active[2],
                  chb.safe_unack[1], chb.acked[1], chb.active[1],
                  chb.safe_unack[0], chb.acked[0], chb.active[0]};

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_have = 1'b1;
      st_next.waddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'b00;
      c = pal_chan_of(st_reg.waddr);
      o = pal_off_of(st_reg.waddr);
      if (c < 3'd4) begin
        unique case (o)
          pal_pkg::OFS_CFG: begin
            st_next.kind[c[1:0]] = st_reg.wdata[pal_pkg::CFG_KIND_LSB +: 3];
            st_next.latch[c[1:0]] =
              st_reg.wdata[pal_pkg::CFG_LATCH_LSB +: 2];
            st_next.block_en[c[1:0]] = st_reg.wdata[pal_pkg::CFG_BLOCK_BIT];
          end
          pal_pkg::OFS_TRIP: st_next.trip[c[1:0]] = st_reg.wdata[15:0];
          pal_pkg::OFS_HYST: st_next.hyst[c[1:0]] = st_reg.wdata[15:0];
          default: st_next.bresp = 2'b10;
        endcase
      end else if (st_reg.waddr == pal_pkg::OFS_MAP)
        st_next.relay_map = st_reg.wdata[15:0];
      else if (st_reg.waddr != pal_pkg::OFS_ACK)
        st_next.bresp = 2'b10;
      if (st_reg.waddr == pal_pkg::OFS_ACK && st_reg.wdata[0])
        st_next.ack = 1'b1;
    end
    if (s_axi_rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'b00;
      st_next.rdata = '0;
      c = pal_chan_of(s_axi_araddr[7:0]);
      o = pal_off_of(s_axi_araddr[7:0]);
      any_unack = 1'b0;
      if (c < 3'd4) begin
        // kind none hides the channel's other settings
        if (st_reg.kind[c[1:0]] == 3'(pal_pkg::KIND_NONE) &&
            o != pal_pkg::OFS_CFG)
          st_next.rdata = '0;
        else begin
          unique case (o)
            pal_pkg::OFS_CFG: st_next.rdata = {23'h0,
              st_reg.block_en[c[1:0]], 2'h0, st_reg.latch[c[1:0]],
              1'b0, st_reg.kind[c[1:0]]};
            pal_pkg::OFS_TRIP: st_next.rdata = {13'h0,
              st_reg.kind[c[1:0]], st_reg.trip[c[1:0]]};
            pal_pkg::OFS_HYST: st_next.rdata = {16'h0, st_reg.hyst[c[1:0]]};
            pal_pkg::OFS_STAT: st_next.rdata = {28'h0,
              chb.safe_unack[c[1:0]], chb.acked[c[1:0]],
              st_reg.cond[c[1:0]], chb.relay_drive[c[1:0]]};
            default: st_next.rresp = 2'b10;
          endcase
        end
      end else begin
        unique case (s_axi_araddr[7:0])
          pal_pkg::OFS_PV: st_next.rdata = {16'h0, process_value};
          pal_pkg::OFS_MAP: st_next.rdata = {16'h0, st_reg.relay_map};
          pal_pkg::OFS_ACK: st_next.rdata = '0;
          pal_pkg::OFS_IND: st_next.rdata = {23'h0, alarm_beacon,
            message_valid, message_kind, message_channel};
          pal_pkg::OFS_NV: st_next.rdata = {20'h0, st_reg.nv};
          default: st_next.rresp = 2'b10;
        endcase
      end
    end
    if (!aresetn) begin
      st_next = '0;
      st_next.kind = {NCH{pal_pkg::KIND_RST}};
      st_next.latch = {NCH{pal_pkg::LATCH_RST}};
      st_next.block_en = {NCH{pal_pkg::BLOCK_RST}};
      st_next.trip = {NCH{pal_pkg::TRIP_RST}};
      st_next.hyst = {NCH{pal_pkg::HYST_RST}};
      st_next.relay_map = pal_pkg::MAP_RST;
    end
  end

  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_comb begin
    logic unack;
    logic acked_any;
    unack = 1'b0;
    acked_any = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      safe_now[i] = !st_reg.cond[i];
      if (st_reg.latch[i] != 2'(pal_pkg::LATCH_EVENT_ONLY)) begin
        if ((chb.active[i] && !chb.acked[i]) || chb.safe_unack[i])
          unack = 1'b1;
        if (chb.active[i] && chb.acked[i])
          acked_any = 1'b1;
      end
    end
    // flashing wins over steady while any channel not set to event-only is unacknowledged
    alarm_beacon = unack ? st_reg.flash : acked_any;
    for (int o = 0; o < pal_pkg::NOUT; o++)
      relay_out[o] = |(st_reg.relay_map[4*o +: 4] & chb.relay_drive);
  end

  assign message_channel = st_reg.msg_ch;
  assign message_kind = st_reg.msg_kind;
  assign message_valid = st_reg.msg_valid;
  assign nv_state_out = st_reg.nv;
  assign s_axi_awready = !st_reg.aw_have;
  assign s_axi_wready = !st_reg.w_have;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
endmodule : pal_top

// ---- tb/pal_partner.sv ----
`timescale 1ns/1ps
module pal_partner (
  input wire logic aclk,
  output logic [15:0] process_value,
  output logic operator_ack
);
  initial begin
    process_value = 16'h0000;
    operator_ack = 1'b0;
  end
  task set_pv(input logic [15:0] v);
    @(posedge aclk);
    process_value <= v;
  endtask : set_pv
  // keypad press reaches the unit as a single clock pulse
  task press();
    @(posedge aclk);
    operator_ack <= 1'b1;
    @(posedge aclk);
    operator_ack <= 1'b0;
  endtask : press
endmodule : pal_partner

// ---- tb/pal_top_assertions.sv ----
`timescale 1ns/1ps
module pal_top_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] nv_state_out,
  input wire logic alarm_beacon,
  input wire logic [3:0] relay_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // nv_state_out lags the state by one cycle, hence $past below
  sequence all_idle;
    nv_state_out == 12'h000;
  endsequence
  bvalid_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bvalid dropped early");
  rvalid_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid) else $error("rvalid dropped early");
  read_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high during read answer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  write_answer_a: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_cause_a: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("stray rvalid");
  relay_idle_a: assert property (all_idle |-> $past(relay_out) == 4'h0)
    else $error("relay on with no alarm");
  beacon_idle_a: assert property (all_idle |-> !$past(alarm_beacon))
    else $error("beacon on with no alarm");
endmodule : pal_top_assertions

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, operator_ack;
  logic nv_restore, alarm_beacon, message_valid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, message_channel, relay_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] process_value, setpoint;
  logic [11:0] nv_state_in, nv_state_out;
  logic [2:0] message_kind;
  logic [31:0] d;
  logic [9:0] tbl [8];
  int failures, n_tests, cyc, k;
  pal_top u_dut (.*);
  pal_partner u_op (.aclk(aclk), .process_value(process_value),
    .operator_ack(operator_ack));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    aw = 1'b0; w = 1'b0; b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h000000, a}; s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = aw | s_axi_awready; w = w | s_axi_wready; b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ar;
    logic done;
    ar = 1'b0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // sampled at the falling edge, so no race with the rising edge update
    while (!done) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // state of channel 0 is {safe_unack, acked, active}
  task exn(input logic [2:0] e);
    repeat (4) @(negedge aclk);
    for (int i = 0; i < 16 && nv_state_out[2:0] !== e; i++) @(negedge aclk);
    chk("ch0 state", {29'h0, e}, {29'h0, nv_state_out[2:0]});
  endtask : exn
  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  logic [1:0] r;
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, nv_restore} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {setpoint, nv_state_in, cyc} = '0;
    s_axi_wstrb = 4'hF;
    tbl = '{10'h00C, 10'h048, 10'h088, 10'h0D8, 10'h0CC, 10'h209,
      10'h388, 10'h3D8};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 8; k++) begin
      wr(8'h00, k);
      rd(8'h04, d, r);
      chk("trip kind", (k == 0) ? 32'h0 : k << 16, d);
    end
    wr(8'h00, 32'h00000001);
    rd(8'h00, d, r);
    chk("cfg default", 32'h00000001, d);
    rd(8'h60, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    wr(8'h04, 32'h000000D7);
    wr(8'h08, 32'h00000002);
    wr(8'h44, 32'h00000001);
    $display("config test done");
    u_op.set_pv(16'h00D8); exn(3'h1);
    chk("relay manual", 32'h1, {28'h0, relay_out});
    chk("message", 32'h91, {24'h0, message_valid, message_kind,
      message_channel});
    u_op.press(); exn(3'h1);
    u_op.set_pv(16'h00D6); exn(3'h1);
    u_op.set_pv(16'h00D4); u_op.press(); exn(3'h0);
    $display("manual test done");
    wr(8'h00, 32'h00000021);
    u_op.set_pv(16'h00D8); exn(3'h1);
    chk("relay on", 32'h1, {28'h0, relay_out});
    u_op.set_pv(16'h0000); exn(3'h0);
    u_op.set_pv(16'h00D8); u_op.press(); exn(3'h3);
    chk("relay acked", 32'h0, {28'h0, relay_out});
    for (k = 0; k < 8; k++) begin
      @(negedge aclk);
      chk("beacon steady", 32'h1, {31'h0, alarm_beacon});
    end
    u_op.set_pv(16'h0000); exn(3'h0);
    wr(8'h00, 32'h00000031);
    u_op.set_pv(16'h00D8); u_op.press(); exn(3'h3);
    u_op.set_pv(16'h0000); exn(3'h0);
    $display("latch test done");
    for (k = 0; k < 8; k++) begin
      wr(8'h00, {23'h0, tbl[k][8], 2'h0, tbl[k][7:6], 4'h1});
      u_op.set_pv(tbl[k][9] ? 16'h00D8 : 16'h0000);
      @(posedge aclk);
      nv_restore <= 1'b1; nv_state_in <= {9'h000, tbl[k][5:3]};
      @(posedge aclk);
      nv_restore <= 1'b0;
      exn(tbl[k][2:0]);
    end
    $display("power cycle test done");
    u_op.set_pv(16'h0000); u_op.set_pv(16'h00D8); exn(3'h1);
    u_op.set_pv(16'h0000); exn(3'h4);
    u_op.press(); exn(3'h0);
    wr(8'h00, 32'h00000023);
    s_axi_wstrb <= 4'h3;
    wr(8'h04, 32'h00000010);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, d, r);
    chk("trip strobe", 32'h00030010, d);
    @(posedge aclk);
    setpoint <= 16'h0100;
    u_op.set_pv(16'h0111); exn(3'h1);
    chk("message dev", 32'hB1, {24'h0, message_valid, message_kind,
      message_channel});
    rd(8'h0C, d, r);
    chk("status", 32'h3, d);
    @(posedge aclk);
    setpoint <= 16'h0110;
    exn(3'h0);
    $display("deviation test done");
    conclude();
  end
endmodule : tb
bind pal_top pal_top_assertions u_chk (.*);
